/* File: fsp_assertions.sv */
// Purpose: Port checks for the flash command gate.
// Assumes: Bound to fsp_core.
// Notes: Delays are fixed eight-cycle windows (six for the frame end), not the package counts.
`timescale 1ns/1ps
module fsp_assertions
	import fsp_pkg::*;
#(
	parameter logic HAS_RESET_PIN = 1'b0
) (
	input wire logic clk_i, // Clock.
	input wire logic sys_rst_i, // Reset.
	input wire logic cs_n_i, // Select.
	input wire logic wip_i, // Busy.
	input wire logic prog_susp_i, // Program held.
	input wire logic erase_susp_i, // Erase held.
	input wire logic wel_o, // Latch.
	input wire logic [7:0] read_param_o, // Parameter.
	input wire logic pin_is_reset_o, // Pin mode.
	input wire logic nv_write_o, // Persist pulse.
	input wire logic [7:0] nv_data_o, // Persist value.
	input wire logic resume_o, // Resume pulse.
	input wire logic cmd_pass_o, // Pass pulse.
	input wire logic [7:0] cmd_op_o, // Pass opcode.
	input wire logic sleep_o, // Asleep.
	input wire logic so_oe_o, // Out enable.
	input wire logic mem_req_o // Array request.
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sleep_mute_a: assert property (sleep_o |-> !cmd_pass_o && !resume_o && !nv_write_o)
		else $error("Command acted while asleep.");
	sleep_entry_a: assert property ($rose(sleep_o) |-> cs_n_i && $past(cs_n_i, 8))
		else $error("Sleep entered without a closed frame.");
	wake_quiet_a: assert property ($fell(sleep_o) |-> (!cmd_pass_o && !resume_o) [*8])
		else $error("Command acted during wake delay.");
	wake_busy_a: assert property (sleep_o && wip_i |=> sleep_o)
		else $error("Woke while write in progress.");
	persist_wel_a: assert property (nv_write_o |-> $past(wel_o) || $past(wel_o, 2))
		else $error("Persistent write without latch.");
	nv_copy_a: assert property (nv_write_o |-> ##[0:2] read_param_o == nv_data_o)
		else $error("Volatile copy not updated.");
	pin_sel_a: assert property (pin_is_reset_o == (HAS_RESET_PIN | $past(read_param_o[7])))
		else $error("Pin mode wrong.");
	prog_gate_a: assert property (cmd_pass_o && prog_susp_i && !erase_susp_i
		|-> !(cmd_op_o inside {8'h02, 8'h32, 8'h38}))
		else $error("Program passed in program suspend.");
	frame_end_a: assert property (cs_n_i [*6] |-> !so_oe_o && !mem_req_o)
		else $error("Output after select rose.");
endmodule : fsp_assertions

bind fsp_core fsp_assertions #(.HAS_RESET_PIN(HAS_RESET_PIN)) chk_u (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .wip_i(wip_i), .prog_susp_i(prog_susp_i),
	.erase_susp_i(erase_susp_i), .wel_o(wel_o), .read_param_o(read_param_o),
	.pin_is_reset_o(pin_is_reset_o), .nv_write_o(nv_write_o), .nv_data_o(nv_data_o),
	.resume_o(resume_o), .cmd_pass_o(cmd_pass_o), .cmd_op_o(cmd_op_o), .sleep_o(sleep_o),
	.so_oe_o(so_oe_o), .mem_req_o(mem_req_o));

/* File: fsp_buf2.sv */
// Purpose: Small valid/ready buffer between the array port and the serialiser.
// Assumes: Depth is two entries by default.
// Notes: Flags are registered so that the ready output comes from a flop.
`timescale 1ns/1ps
module fsp_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_i, // System clock.
	input wire logic sys_rst_i, // Synchronous reset, active high.
	input wire logic flush_i, // Drop all entries.
	input wire logic in_valid_i, // Write side valid.
	output logic in_ready_o, // Write side ready (room left).
	input wire logic [WIDTH-1:0] in_data_i, // Write side data.
	output logic out_valid_o, // Read side valid.
	input wire logic out_ready_i, // Read side ready.
	output logic [WIDTH-1:0] out_data_o // Read side data.
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic room_r;
	logic avail_r;
	logic push;
	logic pop;
	logic [AW:0] cnt_nxt;

	// Handshakes and the next fill level.
	assign push = in_valid_i & room_r & ~flush_i;
	assign pop = out_ready_i & avail_r & ~flush_i;
	assign cnt_nxt = flush_i ? '0 : cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	// Storage, pointers and registered flags.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			room_r <= 1'b1;
			avail_r <= 1'b0;
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data_i;
			end
			if (flush_i) begin
				wp_r <= '0;
				rp_r <= '0;
			end else begin
				if (push) begin
					wp_r <= (wp_r == LAST) ? '0 : wp_r + AW'(1);
				end
				if (pop) begin
					rp_r <= (rp_r == LAST) ? '0 : rp_r + AW'(1);
				end
			end
			cnt_r <= cnt_nxt;
			room_r <= (cnt_nxt != FULL);
			avail_r <= (cnt_nxt != '0);
		end
	end

	assign in_ready_o = room_r;
	assign out_valid_o = avail_r;
	assign out_data_o = mem_r[rp_r];

endmodule : fsp_buf2

/* File: fsp_core.sv */
// Purpose: Command gate, power-down sequencing and read parameter logic of a
//          serial NOR flash, with wrap-aware normal array read.
// Assumes: Link pins are asynchronous and sampled by clk_i; the array port
//          answers a request within two clocks.
// Notes: Contract
// Contract
// R1: Array read opcodes accepted during any suspend.
// R2: Status, function, parameter register reads during suspend.
// R3: Write latch set, error clear accepted in suspend.
// R4: Volatile parameter set commands accepted in suspend.
// R5: Identification, serial number, table reads in suspend.
// R6: Page program only during erase suspend.
// R7: Other opcodes ignored while suspended.
// R8: Sleep entered within entry delay after select rises.
// R9: Asleep, only release opcode recognised.
// R10: Nothing accepted until release delay elapses.
// R11: Release ignored while write in progress.
// R12: Parameter holds wrap, dummy, hold/reset select.
// R13: Dedicated reset pin ignores select bit.
// R14: Persistent parameter set needs write latch.
// R15: Opcode 63h needs latch, C0h does not.
// R16: Persistent set also updates volatile copy.
// R17: Values 4..7 select wrap 8..64 bytes.
// R18: Wrap stays inside aligned burst, ends on select.
// R19: Without wrap, address increments across array.
// R20: Wrap persists until cleared, sleep or reset.
// R21: Resume restarts suspended operation, clears suspend bit.
`timescale 1ns/1ps
module fsp_core
	import fsp_pkg::*;
#(
	parameter logic HAS_RESET_PIN = 1'b0
) (
	input wire logic clk_i, // System clock, 10 MHz.
	input wire logic sys_rst_i, // Synchronous reset, active high.
	input wire logic sck_i, // Link serial clock.
	input wire logic cs_n_i, // Link chip select, active low.
	input wire logic si_i, // Link serial data in.
	output logic so_o, // Link serial data out.
	output logic so_oe_o, // Serial data out enable.
	input wire logic wip_i, // Write in progress from the array core.
	input wire logic prog_susp_i, // Program suspended flag.
	input wire logic erase_susp_i, // Erase suspended flag.
	input wire logic wel_clr_i, // Core clears the write latch.
	output logic wel_o, // Write enable latch.
	output logic [7:0] read_param_o, // Volatile read parameter register.
	output logic pin_is_reset_o, // Shared pin acts as reset.
	output logic nv_write_o, // Persistent parameter write pulse.
	output logic [7:0] nv_data_o, // Persistent parameter value.
	output logic resume_o, // Resume pulse to the array core.
	output logic cmd_pass_o, // Accepted opcode for other logic, pulse.
	output logic [7:0] cmd_op_o, // Opcode that goes with cmd_pass_o.
	output logic sleep_o, // Device is in deep power-down.
	output logic mem_req_o, // Array byte request, pulse.
	output logic [ADDR_W-1:0] mem_addr_o, // Array byte address.
	input wire logic mem_valid_i, // Array byte valid.
	input wire logic [7:0] mem_data_i, // Array byte.
	output logic mem_ready_o // Buffer can take a byte.
);

	// ************************************************************
	// Pin sampling and edge detection
	// ************************************************************
	logic sck_q, cs_n_q, si_q;
	logic sck_d_r, cs_d_r;
	logic sck_rise, sck_fall, cs_rise, cs_fall;

	fsp_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({sck_i, cs_n_i, si_i}),
		.q_o({sck_q, cs_n_q, si_q})
	);

	// Edge flags on the synchronised levels, clock edges only inside a frame.
	assign sck_rise = sck_q & ~sck_d_r & ~cs_n_q;
	assign sck_fall = ~sck_q & sck_d_r & ~cs_n_q;
	assign cs_rise = cs_n_q & ~cs_d_r;
	assign cs_fall = ~cs_n_q & cs_d_r;

	// ************************************************************
	// Command acceptance
	// ************************************************************
	fsp_pd_e pd_r;
	logic [DLY_W-1:0] dly_r;
	logic [5:0] bit_cnt_r;
	logic [7:0] in_sh_r, op_r, opc_now;
	logic [ADDR_W-1:0] addr_sh_r;
	logic op_ok_r, opc_done, suspended, allowed, handled;

	// Opcodes permitted while suspended; page program and the erase-only
	// group need an erase suspend.
	function automatic logic susp_ok(input logic [7:0] op, input logic erase);
		logic ok;
		ok = 1'b0;
		unique case (op)
			8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed: ok = 1'b1; // [R1]
			8'h05, 8'h48, 8'h61, 8'h81: ok = 1'b1; // [R2]
			8'h06, 8'h04, 8'h82: ok = 1'b1; // [R3]
			8'hc0, 8'h63, 8'h83: ok = 1'b1; // [R4]
			8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a: ok = 1'b1; // [R5]
			8'h7a, 8'h30, 8'hfc, 8'hfa, 8'he7, 8'ha7, 8'h2b: ok = 1'b1;
			8'h02, 8'h32, 8'h38, 8'h24, 8'h26, 8'h75, 8'hb0, 8'hfb: ok = erase; // [R6]
			default: ok = 1'b0; // [R7]
		endcase
		return ok;
	endfunction : susp_ok

	// Decide on the opcode as its eighth bit arrives.
	assign opc_now = {in_sh_r[6:0], si_q};
	assign opc_done = sck_rise & (bit_cnt_r == OPC_BITS - 6'h01);
	assign suspended = prog_susp_i | erase_susp_i;
	assign allowed = (pd_r == FSP_PD_AWAKE) ? (~suspended | susp_ok(opc_now, erase_susp_i)) :
		(pd_r == FSP_PD_ASLEEP) ? ((opc_now == OP_SLEEP_RELEASE) & ~wip_i) : // [R9] [R11]
		1'b0; // [R10]
	assign handled = (opc_now == OP_SET_WRITE_LATCH) | (opc_now == OP_CLEAR_WRITE_LATCH) |
		(opc_now == OP_STATUS_READ) | (opc_now == OP_FUNCTION_READ) |
		(opc_now == OP_PARAM_READ) | (opc_now == OP_PARAM_SET_VOL_A) |
		(opc_now == OP_PARAM_SET_VOL_B) | (opc_now == OP_PARAM_SET_PERSIST) |
		(opc_now == OP_RESUME_A) | (opc_now == OP_RESUME_B) |
		(opc_now == OP_SLEEP_ENTER) | (opc_now == OP_NORMAL_ARRAY_READ) |
		(pd_r != FSP_PD_AWAKE);

	// Frame shifter, bit counter and the latched opcode.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bit_cnt_r <= '0;
			in_sh_r <= '0;
			addr_sh_r <= '0;
			op_r <= '0;
			op_ok_r <= 1'b0;
			cmd_pass_o <= 1'b0;
			cmd_op_o <= '0;
		end else begin
			cmd_pass_o <= opc_done & allowed & ~handled;
			if (cs_fall) begin
				bit_cnt_r <= '0;
				op_ok_r <= 1'b0;
			end else if (sck_rise) begin
				in_sh_r <= opc_now;
				addr_sh_r <= {addr_sh_r[ADDR_W-2:0], si_q};
				if (bit_cnt_r != BITCNT_MAX) begin
					bit_cnt_r <= bit_cnt_r + 6'h01;
				end
				if (opc_done) begin
					op_r <= opc_now;
					op_ok_r <= allowed; // [R7] [R9]
					cmd_op_o <= opc_now;
				end
			end
		end
	end

	// ************************************************************
	// Commit at the end of a frame
	// ************************************************************
	logic commit_one, commit_param, param_exec, is_persist, sleep_go;

	// One-byte commands act only if select rises right after the opcode.
	assign commit_one = cs_rise & op_ok_r & (bit_cnt_r == OPC_BITS); // [R8]
	assign commit_param = cs_rise & op_ok_r & (bit_cnt_r == PARAM_END) &
		((op_r == OP_PARAM_SET_VOL_A) | (op_r == OP_PARAM_SET_VOL_B) |
		(op_r == OP_PARAM_SET_PERSIST));
	assign param_exec = commit_param & ((op_r == OP_PARAM_SET_VOL_A) | wel_o); // [R14] [R15]
	assign is_persist = op_r == OP_PARAM_SET_PERSIST;
	assign sleep_go = commit_one & (op_r == OP_SLEEP_ENTER) & (pd_r == FSP_PD_AWAKE);

	// Write latch; a set in the same cycle as a clear wins.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wel_o <= 1'b0;
		end else if (commit_one & (op_r == OP_SET_WRITE_LATCH)) begin
			wel_o <= 1'b1;
		end else if (wel_clr_i | (commit_one & (op_r == OP_CLEAR_WRITE_LATCH)) |
			(param_exec & (op_r != OP_PARAM_SET_VOL_A))) begin
			wel_o <= 1'b0; // [R15]
		end
	end

	// Read parameter register, persistent copy and pin function select.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			read_param_o <= RP_RESET; // [R20]
			nv_write_o <= 1'b0;
			nv_data_o <= RP_RESET;
			pin_is_reset_o <= HAS_RESET_PIN;
			resume_o <= 1'b0;
		end else begin
			nv_write_o <= param_exec & is_persist;
			resume_o <= commit_one & ((op_r == OP_RESUME_A) | (op_r == OP_RESUME_B)); // [R21]
			pin_is_reset_o <= HAS_RESET_PIN | read_param_o[RP_HOLD_RESET_BIT]; // [R12] [R13]
			if (param_exec) begin
				read_param_o <= in_sh_r; // [R12] [R16] [R20]
				if (is_persist) begin
					nv_data_o <= in_sh_r;
				end
			end else if (sleep_go) begin
				read_param_o[RP_WRAP_BIT] <= 1'b0; // [R20]
			end
		end
	end

	// ************************************************************
	// Deep power-down sequencing
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pd_r <= FSP_PD_AWAKE;
			dly_r <= '0;
			sleep_o <= 1'b0;
		end else begin
			unique case (pd_r)
				FSP_PD_AWAKE: begin
					if (sleep_go) begin
						pd_r <= FSP_PD_ENTER;
						dly_r <= ENTRY_CNT; // [R8]
					end
				end
				FSP_PD_ENTER: begin
					dly_r <= dly_r - DLY_ONE;
					if (dly_r == DLY_ONE) begin
						pd_r <= FSP_PD_ASLEEP;
						sleep_o <= 1'b1;
					end
				end
				FSP_PD_ASLEEP: begin
					if (commit_one) begin
						pd_r <= FSP_PD_WAKE;
						dly_r <= RELEASE_CNT; // [R10]
					end
				end
				FSP_PD_WAKE: begin
					sleep_o <= 1'b0;
					dly_r <= dly_r - DLY_ONE;
					if (dly_r == DLY_ONE) begin
						pd_r <= FSP_PD_AWAKE; // [R10]
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Array read addressing and buffer
	// ************************************************************
	logic arr_go_r, inflight_r, buf_room, buf_valid, buf_pop, issue, wrap_on, start_rd;
	logic [7:0] buf_data, burst_mask, lo_inc;
	logic [ADDR_W-1:0] rd_addr_r, addr_next, start_addr, cur_addr;

	// Next address: within the aligned burst when wrap is on, else linear. The first request
	// leaves with the last address bit, so a two-clock array answer still meets the first fall.
	assign start_rd = sck_rise & ~cs_fall & op_ok_r & (op_r == OP_NORMAL_ARRAY_READ) &
		(bit_cnt_r == ADDR_END - 6'h01);
	assign start_addr = {addr_sh_r[ADDR_W-2:0], si_q};
	assign cur_addr = start_rd ? start_addr : rd_addr_r;
	assign wrap_on = read_param_o[RP_WRAP_BIT]; // [R17]
	assign burst_mask = (BURST_MIN << read_param_o[RP_LEN_LSB +: 2]) - 8'h01; // [R17]
	assign lo_inc = cur_addr[7:0] + 8'h01;
	assign addr_next = wrap_on ?
		{cur_addr[ADDR_W-1:8], (cur_addr[7:0] & ~burst_mask) | (lo_inc & burst_mask)} : // [R18]
		cur_addr + ADDR_W'(1); // [R19]
	assign issue = (arr_go_r | start_rd) & buf_room & ~inflight_r & ~mem_req_o;

	fsp_buf2 #(.WIDTH(8), .DEPTH(2)) u_buf (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.flush_i(cs_rise),
		.in_valid_i(mem_valid_i & arr_go_r),
		.in_ready_o(buf_room),
		.in_data_i(mem_data_i),
		.out_valid_o(buf_valid),
		.out_ready_i(buf_pop),
		.out_data_o(buf_data)
	);

	// Requests start once the address is in and stop when select rises.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			arr_go_r <= 1'b0;
			rd_addr_r <= '0;
			inflight_r <= 1'b0;
			mem_req_o <= 1'b0;
			mem_addr_o <= '0;
		end else begin
			mem_req_o <= issue;
			if (issue) begin
				mem_addr_o <= cur_addr;
				rd_addr_r <= addr_next; // [R18] [R19]
				inflight_r <= 1'b1;
			end else if (mem_valid_i & buf_room) begin
				inflight_r <= 1'b0;
			end
			if (cs_rise | cs_fall) begin
				arr_go_r <= 1'b0; // [R18]
			end else if (start_rd) begin
				arr_go_r <= 1'b1;
			end
		end
	end

	assign mem_ready_o = buf_room;

	// ************************************************************
	// Serial output
	// ************************************************************
	logic reg_rd, out_go;
	logic [2:0] out_idx_r;
	logic [7:0] out_sh_r, status_byte, func_byte, reg_byte, load_byte;

	// Readable registers; reads run during suspend when accepted.
	always_comb begin
		status_byte = '0;
		status_byte[SR_WIP_BIT] = wip_i;
		status_byte[SR_WEL_BIT] = wel_o;
		func_byte = '0;
		func_byte[FR_PSUS_BIT] = prog_susp_i;
		func_byte[FR_ESUS_BIT] = erase_susp_i;
	end

	assign reg_rd = op_ok_r & ((op_r == OP_STATUS_READ) | (op_r == OP_FUNCTION_READ) |
		(op_r == OP_PARAM_READ)); // [R2]
	assign reg_byte = (op_r == OP_STATUS_READ) ? status_byte :
		(op_r == OP_FUNCTION_READ) ? func_byte : read_param_o;
	assign out_go = sck_fall & ((reg_rd & (bit_cnt_r >= OPC_BITS)) |
		(arr_go_r & (bit_cnt_r >= ADDR_END))); // [R1]
	assign buf_pop = out_go & arr_go_r & (out_idx_r == 3'h0);
	assign load_byte = arr_go_r ? (buf_valid ? buf_data : IDLE_BYTE) : reg_byte;

	// Shift each byte out MSB first on falling clock edges.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			out_idx_r <= '0;
			out_sh_r <= '0;
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
		end else begin
			sck_d_r <= sck_q;
			cs_d_r <= cs_n_q;
			if (cs_rise | cs_fall) begin
				out_idx_r <= '0;
				so_oe_o <= 1'b0;
			end else if (out_go) begin
				so_oe_o <= 1'b1;
				out_idx_r <= out_idx_r + 3'h1;
				if (out_idx_r == 3'h0) begin
					so_o <= load_byte[7];
					out_sh_r <= {load_byte[6:0], 1'b0};
				end else begin
					so_o <= out_sh_r[7];
					out_sh_r <= {out_sh_r[6:0], 1'b0};
				end
			end
		end
	end

endmodule : fsp_core

/* File: fsp_core_test.sv */
// Purpose: Self-checking bench for fsp_core.
// Assumes: Link clock period 800 ns, mode 0.
// Notes: Frames are driven on falling clock edges.
`timescale 1ns/1ps
module fsp_core_test;
	import fsp_pkg::*;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, sck_i = 1'b0, cs_n_i = 1'b1, si_i = 1'b0;
	logic wip_i = 1'b0, prog_susp_i = 1'b0, erase_susp_i = 1'b0, wel_clr_i = 1'b0;
	logic slow_i = 1'b0, so_o, so_oe_o, wel_o, pin_is_reset_o, nv_write_o, resume_o;
	logic cmd_pass_o, sleep_o, mem_req_o, mem_valid_i, mem_ready_o;
	logic [7:0] read_param_o, nv_data_o, cmd_op_o, mem_data_i, last_op;
	logic [ADDR_W-1:0] mem_addr_o;
	logic [63:0] rx;
	logic [7:0] ok_ops [8] = '{8'heb, 8'hed, 8'h9f, 8'h5a, 8'h82, 8'h83, 8'h81, 8'hab};
	logic [7:0] bad_ops [4] = '{8'h02, 8'h32, 8'h38, 8'h01};
	int failures = 0, comparisons = 0, npass = 0, nres = 0, noe = 0, n0;

	fsp_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
		.si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .wip_i(wip_i), .prog_susp_i(prog_susp_i),
		.erase_susp_i(erase_susp_i), .wel_clr_i(wel_clr_i), .wel_o(wel_o),
		.read_param_o(read_param_o), .pin_is_reset_o(pin_is_reset_o), .nv_write_o(nv_write_o),
		.nv_data_o(nv_data_o), .resume_o(resume_o), .cmd_pass_o(cmd_pass_o), .cmd_op_o(cmd_op_o),
		.sleep_o(sleep_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
		.mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .mem_ready_o(mem_ready_o));
	fsp_mem_model mem_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .slow_i(slow_i), .valid_o(mem_valid_i), .data_o(mem_data_i));

	// Clock of 100 ns.
	always #50 clk_i = ~clk_i;

	// Records pulses and output drive, sampled mid-cycle where they are settled.
	always @(negedge clk_i) begin
		if (cmd_pass_o === 1'b1) begin
			npass++;
			last_op = cmd_op_o;
		end
		if (resume_o === 1'b1) nres++;
		if (so_oe_o === 1'b1) noe++;
	end

	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One frame: n bits sent MSB first, then rn bits read; select then stays high.
	task automatic spi(input logic [31:0] tx, input int n, input int rn);
		rx = '0;
		@(negedge clk_i) cs_n_i = 1'b0;
		for (int i = 0; i < n + rn; i++) begin
			sck_i = 1'b0;
			si_i = (i < n) ? tx[n-1-i] : 1'b0;
			repeat (4) @(negedge clk_i);
			sck_i = 1'b1;
			repeat (3) @(negedge clk_i);
			if (i >= n) rx = {rx[62:0], so_o};
			@(negedge clk_i);
		end
		sck_i = 1'b0;
		repeat (4) @(negedge clk_i);
		cs_n_i = 1'b1;
		repeat (60) @(negedge clk_i);
	endtask : spi

	task automatic final_report();
		if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// Cuts a hang short.
	initial begin
		repeat (60000) @(posedge clk_i);
		failures++;
		final_report();
	end

	// Main sequence.
	initial begin
		repeat (5) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		chk("reset", {read_param_o, mem_ready_o, so_oe_o, sleep_o}, 11'h004);
		spi(32'h63a5, 16, 0);
		chk("param", read_param_o, 8'h00);
		spi(32'h06, 8, 0);
		spi(32'h6385, 16, 0);
		chk("param wel pin", {read_param_o, wel_o, pin_is_reset_o}, 10'h215);
		spi(32'h6521, 16, 0);
		chk("param", read_param_o, 8'h85);
		spi(32'h06, 8, 0);
		spi(32'h6521, 16, 0);
		chk("persist", {nv_data_o, read_param_o}, 16'h2121);
		prog_susp_i = 1'b1;
		spi(32'h48, 8, 8);
		chk("function", rx, 64'h04);
		spi(32'h06, 8, 0);
		spi(32'h05, 8, 8);
		chk("status", rx, 64'h02);
		spi(32'h04, 8, 0);
		chk("wel", wel_o, 1'b0);
		for (int k = 0; k < 8; k++) begin
			spi({24'h0, ok_ops[k]}, 8, 0);
			chk("pass", last_op, ok_ops[k]);
		end
		n0 = npass;
		for (int k = 0; k < 4; k++) spi({24'h0, bad_ops[k]}, 8, 0);
		chk("refused", npass, n0);
		prog_susp_i = 1'b0;
		erase_susp_i = 1'b1;
		for (int k = 0; k < 3; k++) begin
			spi({24'h0, bad_ops[k]}, 8, 0);
			chk("program", last_op, bad_ops[k]);
		end
		for (int l = 0; l < 4; l++) begin
			slow_i = l[0];
			spi(32'hc004 + l, 16, 0);
			spi(32'h03000080 + (8 << l) - 1, 32, 16);
			chk("wrap", rx, 16'h7f80 + ((8 << l) << 8));
		end
		spi(32'hc000, 16, 0);
		spi(32'h030000fe, 32, 24);
		chk("linear", rx, 64'hfeff00);
		spi(32'h7a, 8, 0);
		chk("resume", nres, 1);
		spi(32'h06, 8, 0);
		chk("wel set", wel_o, 1'b1);
		@(negedge clk_i) wel_clr_i = 1'b1;
		@(negedge clk_i) wel_clr_i = 1'b0;
		chk("wel clear", wel_o, 1'b0);
		erase_susp_i = 1'b0;
		spi(32'hc004, 16, 0);
		spi(32'hb9, 8, 0);
		chk("sleep wrap", {sleep_o, read_param_o[2]}, 2'b10);
		spi(32'h06, 8, 0);
		n0 = noe;
		spi(32'h05, 8, 8);
		chk("asleep", {wel_o, rx[7:0]}, 9'h0);
		chk("asleep oe", noe, n0);
		wip_i = 1'b1;
		spi(32'hab, 8, 0);
		chk("sleep", sleep_o, 1'b1);
		wip_i = 1'b0;
		spi(32'hab, 8, 0);
		chk("sleep", sleep_o, 1'b0);
		final_report();
	end
endmodule : fsp_core_test

/* File: fsp_mem_model.sv */
// Purpose: Array side partner answering byte requests.
// Assumes: One request outstanding.
// Notes: Byte value is the low address byte.
`timescale 1ns/1ps
module fsp_mem_model
	import fsp_pkg::*;
(
	input wire logic clk_i, // Clock.
	input wire logic sys_rst_i, // Reset.
	input wire logic req_i, // Request.
	input wire logic [ADDR_W-1:0] addr_i, // Address.
	input wire logic slow_i, // Answer after two clocks.
	output logic valid_o, // Byte valid.
	output logic [7:0] data_o // Byte.
);
	logic [1:0] cnt_r;
	logic [7:0] byte_r;
	// Counts down the answer latency of one or two clocks.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= 2'h0;
		end else if (req_i) begin
			cnt_r <= slow_i ? 2'h2 : 2'h1;
		end else if (cnt_r != 2'h0) begin
			cnt_r <= cnt_r - 2'h1;
		end
		if (req_i) begin
			byte_r <= addr_i[7:0];
		end
	end
	// Outside the answer the data shows the inverse, never a stale copy.
	assign valid_o = (cnt_r == 2'h1);
	assign data_o = valid_o ? byte_r : ~byte_r;
endmodule : fsp_mem_model

/* File: fsp_pkg.sv */
// Purpose: Shared constants for the flash command gate and read parameter logic.
// Assumes: A 10 MHz system clock, single-bit serial framing on the link.
// Notes: Named opcodes, field positions, reset values and delay counts live here; the core's suspend table uses raw opcodes.
package fsp_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int SLEEP_RELEASE_DELAY_NS = 5000;
	// Entry is a longest time (round down), release a least time (round up).
	localparam int ENTRY_CYC_RAW = SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
	localparam int ENTRY_CYC = (ENTRY_CYC_RAW < 1) ? 1 : ENTRY_CYC_RAW;
	localparam int RELEASE_CYC = (SLEEP_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W = 8;
	localparam logic [DLY_W-1:0] ENTRY_CNT = DLY_W'(ENTRY_CYC);
	localparam logic [DLY_W-1:0] RELEASE_CNT = DLY_W'(RELEASE_CYC);
	localparam logic [DLY_W-1:0] DLY_ONE = 8'h01;

	// ************************************************************
	// Framing and addressing
	// ************************************************************
	localparam int ADDR_W = 23;
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] PARAM_END = 6'h10;
	localparam logic [5:0] ADDR_END = 6'h20;
	localparam logic [5:0] BITCNT_MAX = 6'h3f;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam logic [7:0] BURST_MIN = 8'h08;

	// ************************************************************
	// Read parameter, status and function register fields
	// ************************************************************
	localparam logic [7:0] RP_RESET = 8'h00;
	localparam int RP_LEN_LSB = 0;
	localparam int RP_WRAP_BIT = 2;
	localparam int RP_HOLD_RESET_BIT = 7;
	localparam int SR_WIP_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam int FR_PSUS_BIT = 2;
	localparam int FR_ESUS_BIT = 3;

	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_NORMAL_ARRAY_READ = 8'h03;
	localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
	localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_FUNCTION_READ = 8'h48;
	localparam logic [7:0] OP_PARAM_READ = 8'h61;
	localparam logic [7:0] OP_PARAM_SET_VOL_A = 8'hc0;
	localparam logic [7:0] OP_PARAM_SET_VOL_B = 8'h63;
	localparam logic [7:0] OP_PARAM_SET_PERSIST = 8'h65;
	localparam logic [7:0] OP_RESUME_A = 8'h7a;
	localparam logic [7:0] OP_RESUME_B = 8'h30;
	localparam logic [7:0] OP_SLEEP_ENTER = 8'hb9;
	localparam logic [7:0] OP_SLEEP_RELEASE = 8'hab;

	// Power-down sequencing states.
	typedef enum logic [3:0] {
		FSP_PD_AWAKE = 4'b0001,
		FSP_PD_ENTER = 4'b0010,
		FSP_PD_ASLEEP = 4'b0100,
		FSP_PD_WAKE = 4'b1000
	} fsp_pd_e;

endpackage : fsp_pkg

/* File: fsp_sync.sv */
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module fsp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i, // System clock.
	input wire logic sys_rst_i, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] d_i, // Asynchronous levels.
	output logic [WIDTH-1:0] q_o // Synchronised levels.
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;

	// Two stages in series.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end

	assign q_o = q_r;

endmodule : fsp_sync
